//--- pkg/pim_pkg.sv
/*
 * Shared constants of the peripheral interrupt enable mask block: register
 * byte offsets, bit positions of the five gated sources and of the two
 * upper-level enables, and reset values.
 * Assumes a 32-bit APB register bus with byte addresses and aligned words.
 */
package pim_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets.
   localparam logic [7:0] PIM_OFS_CTRL = 8'h80; // Global and group enables.
   localparam logic [7:0] PIM_OFS_STAT = 8'h84; // Sticky event status, read clears.
   localparam logic [7:0] PIM_OFS_IMSK = 8'h88; // Interrupt output mask.
   localparam logic [7:0] PIM_OFS_MASK = 8'h8C; // Peripheral enable mask.
   localparam logic [7:0] PIM_OFS_FLAG = 8'h90; // Read-only view of source flags.

   // Narrowest address bus that reaches every offset above.
   localparam int PIM_ADDR_W_MIN = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Bit positions inside the mask, flag, status and interrupt mask words.
   localparam int PIM_BIT_TIMER_ONE_OVF = 0;
   localparam int PIM_BIT_TIMER_TWO_MATCH = 1;
   localparam int PIM_BIT_CAPCMP_ONE = 2;
   localparam int PIM_BIT_SERIAL_PORT = 3;
   localparam int PIM_BIT_CONVERTER_DONE = 6;
   localparam int PIM_REG_W = 8;

   // Positions of the two enables in the control word.
   localparam int PIM_BIT_GROUP_EN = 6;
   localparam int PIM_BIT_GLOBAL_EN = 7;

   // Positions that carry a gated source; the rest are reserved.
   localparam logic [7:0] PIM_SRC_BITS = 8'h4F;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [7:0] PIM_RST_MASK = 8'h00;
   localparam logic [7:0] PIM_RST_CTRL = 8'h00;
   localparam logic [7:0] PIM_RST_STAT = 8'h00;
   localparam logic [7:0] PIM_RST_IMSK = 8'h00;
   localparam logic [31:0] PIM_RDATA_RST = 32'h0000_0000;

endpackage

//--- rtl/pim_top.sv
/*
 * Peripheral interrupt enable mask with an APB register slave. Holds the
 * eight-bit peripheral enable mask, the global and peripheral group enables,
 * and a sticky event status with its own mask behind one interrupt output.
 * Assumes the peripheral flag register lives outside and presents its eight
 * flag bits as levels synchronous to pclk; the core samples the request.
 */
// Notes on behaviour
// - The peripheral enable mask sits at byte address 8Ch, is eight bits, all read/write, reset 0.
// - Mask bit 6 lets the converter-done flag request an interrupt when one, blocks it when zero.
// - Mask bit 3 lets the serial port flag request an interrupt when one, blocks it when zero.
// - Mask bit 1 lets the timer two period match flag request when one, blocks it when zero.
// - Mask bit 0 lets the timer one overflow flag request when one, blocks it when zero.
// - No peripheral request reaches the core unless the peripheral group enable is set.
// - The flags are never altered by the mask or the enables; the mask gates the request and the status events, the enables only the request.
`timescale 1ns/100ps

module pim_top #(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Peripheral flag levels from the flag register.
   input wire logic [7:0] periph_flags,
   // Request to the core and block interrupt.
   output logic periph_irq_req,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration check: the address bus must reach the highest offset.
   if (ADDR_W < pim_pkg::PIM_ADDR_W_MIN) begin : g_addr_check
      $error("pim_top: ADDR_W too small for the register map.");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register state.
   logic [7:0] peripheral_irq_mask_one_q;
   logic [7:0] main_irq_control_q;
   logic [7:0] stat_q;
   logic [7:0] stat_d;
   logic [7:0] imsk_q;
   logic [7:0] gated_src;
   logic [7:0] gated_prev_q;
   logic [7:0] stat_set;
   logic [7:0] stat_clr;
   logic [31:0] prdata_q;
   logic [31:0] rd_word;
   logic global_irq_en;
   logic peripheral_group_irq_en;
   logic addr_hit;
   logic setup_ph;
   logic access_ph;
   logic wr_en;
   logic rd_en;
   logic [7:0] wbyte;
   logic [7:0] word_ofs;

   // Only the low eight address bits decode; higher bits must be zero.
   assign word_ofs = paddr[7:0];
   assign wbyte = pwdata[7:0];
   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode. Upper address bits above the map make an access unmapped.
   always_comb begin
      addr_hit = 1'b0;
      if ((ADDR_W == pim_pkg::PIM_ADDR_W_MIN) ||
          (paddr >> pim_pkg::PIM_ADDR_W_MIN) == '0) begin
         case (word_ofs)
            pim_pkg::PIM_OFS_CTRL: addr_hit = 1'b1;
            pim_pkg::PIM_OFS_STAT: addr_hit = 1'b1;
            pim_pkg::PIM_OFS_IMSK: addr_hit = 1'b1;
            pim_pkg::PIM_OFS_MASK: addr_hit = 1'b1;
            pim_pkg::PIM_OFS_FLAG: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
         endcase
      end
   end

   // Zero wait states: the read word is caught in the setup cycle, so the
   // access cycle can finish at once while prdata still comes from a flop.
   assign pready = 1'b1;
   assign pslverr = access_ph & ~addr_hit;
   assign wr_en = access_ph & pwrite & addr_hit;
   assign rd_en = access_ph & ~pwrite & addr_hit;
   assign prdata = prdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer; bits above the eight-bit registers read as zero.
   always_comb begin
      rd_word = 32'h0000_0000;
      case (word_ofs)
         pim_pkg::PIM_OFS_CTRL: rd_word[7:0] = main_irq_control_q;
         pim_pkg::PIM_OFS_STAT: rd_word[7:0] = stat_q;
         pim_pkg::PIM_OFS_IMSK: rd_word[7:0] = imsk_q;
         pim_pkg::PIM_OFS_MASK: rd_word[7:0] = peripheral_irq_mask_one_q;
         pim_pkg::PIM_OFS_FLAG: rd_word[7:0] = periph_flags;
         default: rd_word = 32'h0000_0000;
      endcase
      if (!addr_hit) begin
         rd_word = 32'h0000_0000;
      end
   end

   // Read data register, loaded in the setup cycle of a read.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= pim_pkg::PIM_RDATA_RST;
      end else if (setup_ph && !pwrite) begin
         prdata_q <= rd_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral enable mask. All eight bits store what is written, reserved
   // ones too, so a read returns exactly what software left there.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peripheral_irq_mask_one_q <= pim_pkg::PIM_RST_MASK;
      end else if (wr_en && word_ofs == pim_pkg::PIM_OFS_MASK) begin
         peripheral_irq_mask_one_q <= wbyte;
      end
   end

   // Global and peripheral group enables.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_irq_control_q <= pim_pkg::PIM_RST_CTRL;
      end else if (wr_en && word_ofs == pim_pkg::PIM_OFS_CTRL) begin
         main_irq_control_q <= wbyte;
      end
   end

   // Interrupt output mask.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imsk_q <= pim_pkg::PIM_RST_IMSK;
      end else if (wr_en && word_ofs == pim_pkg::PIM_OFS_IMSK) begin
         imsk_q <= wbyte;
      end
   end

   assign global_irq_en = main_irq_control_q[pim_pkg::PIM_BIT_GLOBAL_EN];
   assign peripheral_group_irq_en = main_irq_control_q[pim_pkg::PIM_BIT_GROUP_EN];

   ////////////////////////////////////////////////////////////////////////////
   // Per-source gating. Reserved positions never gate anything, so a stray
   // one written there (software should not) cannot raise a request.
   // The flags pass straight through here and are never changed by the mask.
   for (genvar i = 0; i < pim_pkg::PIM_REG_W; i++) begin : g_gate
      if (pim_pkg::PIM_SRC_BITS[i]) begin : g_src
         // Bits 0, 1, 2, 3 and 6 each enable their own source flag.
         assign gated_src[i] = periph_flags[i] & peripheral_irq_mask_one_q[i];
      end else begin : g_rsv
         assign gated_src[i] = 1'b0;
      end
   end

   // Named taps of the gating, one per source.
   logic converter_done_irq_en;
   logic serial_port_irq_en;
   logic capcmp_one_irq_en;
   logic timer_two_match_irq_en;
   logic timer_one_overflow_irq_en;
   assign converter_done_irq_en = peripheral_irq_mask_one_q[pim_pkg::PIM_BIT_CONVERTER_DONE];
   assign serial_port_irq_en = peripheral_irq_mask_one_q[pim_pkg::PIM_BIT_SERIAL_PORT];
   assign capcmp_one_irq_en = peripheral_irq_mask_one_q[pim_pkg::PIM_BIT_CAPCMP_ONE];
   assign timer_two_match_irq_en = peripheral_irq_mask_one_q[pim_pkg::PIM_BIT_TIMER_TWO_MATCH];
   assign timer_one_overflow_irq_en = peripheral_irq_mask_one_q[pim_pkg::PIM_BIT_TIMER_ONE_OVF];

   // Request to the core: any enabled flag, passed only while both the group
   // and the global enable are set. Combinational so the core sees it at once.
   always_comb begin
      periph_irq_req = 1'b0;
      if (converter_done_irq_en && periph_flags[pim_pkg::PIM_BIT_CONVERTER_DONE]) begin
         periph_irq_req = 1'b1;
      end
      if (serial_port_irq_en && periph_flags[pim_pkg::PIM_BIT_SERIAL_PORT]) begin
         periph_irq_req = 1'b1;
      end
      if (capcmp_one_irq_en && periph_flags[pim_pkg::PIM_BIT_CAPCMP_ONE]) begin
         periph_irq_req = 1'b1;
      end
      if (timer_two_match_irq_en && periph_flags[pim_pkg::PIM_BIT_TIMER_TWO_MATCH]) begin
         periph_irq_req = 1'b1;
      end
      if (timer_one_overflow_irq_en && periph_flags[pim_pkg::PIM_BIT_TIMER_ONE_OVF]) begin
         periph_irq_req = 1'b1;
      end
      if (!peripheral_group_irq_en || !global_irq_en) begin
         periph_irq_req = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event status. A rising edge of a gated source sets its sticky bit; a read
   // of the status word clears it, but a set in the same cycle wins so that
   // no event is lost. The flags themselves stay untouched.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gated_prev_q <= 8'h00;
      end else begin
         gated_prev_q <= gated_src;
      end
   end

   assign stat_set = gated_src & ~gated_prev_q;
   // The read clears only the bits it returned, caught in its setup cycle, so an
   // event that lands between setup and access is kept for the next read.
   assign stat_clr = (rd_en && word_ofs == pim_pkg::PIM_OFS_STAT) ? prdata_q[7:0] : 8'h00;
   assign stat_d = (stat_q & ~stat_clr) | stat_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= pim_pkg::PIM_RST_STAT;
      end else begin
         stat_q <= stat_d;
      end
   end

   // Level interrupt: high while any unmasked status bit is set.
   assign irq = |(stat_q & imsk_q);

endmodule

//--- verification/pim_flag_src.sv
/*
 * Flag source model: the peripheral flag register beside the mask block.
 * Assumes the bench pulses set and clear events after a rising edge of pclk.
 */
`timescale 1ns/100ps

module pim_flag_src (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Event pulses from the bench.
   input wire logic [7:0] set_ev,
   input wire logic [7:0] clr_ev,
   // Flag levels to the block.
   output logic [7:0] periph_flags
);
   // Flags set on their events whatever the masks hold; only software clears them.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_flags <= 8'h00;
      end else begin
         periph_flags <= (periph_flags & ~clr_ev) | set_ev;
      end
   end
endmodule

//--- verification/pim_checker.sv
/*
 * Checker for the peripheral enable mask, watching only the top-level ports.
 * Assumes it is bound into pim_top; it mirrors the mask and control words.
 */
`timescale 1ns/100ps

module pim_checker #(
   parameter int ADDR_W = 8
) (
   // Clock, reset and APB.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Flags and requests.
   input wire logic [7:0] periph_flags,
   input wire logic periph_irq_req,
   input wire logic irq
);
   logic [7:0] mask_q;
   logic [7:0] ctrl_q;
   logic acc;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign acc = psel && penable && pready;
   ////////////////////////////////////////////////////////////////////////////
   // Mirror of the two words; a write lands at the edge ending its access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= 8'h00;
         ctrl_q <= 8'h00;
      end else if (acc && pwrite) begin
         if (paddr == pim_pkg::PIM_OFS_MASK) mask_q <= pwdata[7:0];
         if (paddr == pim_pkg::PIM_OFS_CTRL) ctrl_q <= pwdata[7:0];
      end
   end
   // One source gated alone: the request equals its flag and mask bit.
   property p_gate(int b);
      (ctrl_q[7:6] == 2'b11 && (periph_flags & mask_q & 8'h4F & ~(8'h01 << b)) == 8'h00)
         |-> periph_irq_req == (periph_flags[b] & mask_q[b]);
   endproperty
   a_gate_converter: assert property (p_gate(6)) else $error("converter gate wrong");
   a_gate_serial: assert property (p_gate(3)) else $error("serial gate wrong");
   a_gate_timer_two: assert property (p_gate(1)) else $error("timer two gate wrong");
   a_gate_timer_one: assert property (p_gate(0)) else $error("timer one gate wrong");
   a_gate_capcmp: assert property (p_gate(2)) else $error("capcmp gate wrong");
   a_group_blocks: assert property (!ctrl_q[6] |-> !periph_irq_req)
      else $error("request without group enable");
   a_global_blocks: assert property (!ctrl_q[7] |-> !periph_irq_req)
      else $error("request without global enable");
   a_mask_read: assert property (acc && !pwrite && paddr == pim_pkg::PIM_OFS_MASK
      |-> prdata == {24'h000000, mask_q}) else $error("mask read back wrong");
   a_flag_view: assert property (acc && !pwrite && paddr == pim_pkg::PIM_OFS_FLAG
      |-> prdata[7:0] == $past(periph_flags)) else $error("flag view altered");
   c_request: cover property (periph_irq_req);
   c_irq: cover property (irq);
   c_error: cover property (pslverr);
endmodule

//--- verification/tb.sv
/*
 * Testbench for pim_top: APB tasks, a flag source model, and directed tests.
 * Assumes pim_pkg is compiled first; the checker is bound below the module.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module tb;
   localparam int ADDR_W = 8;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, set_ev = 8'h00, clr_ev = 8'h00, b;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, periph_irq_req, irq;
   logic [7:0] periph_flags;
   int check_count = 0, fail_count = 0;
   int src [5] = '{6, 3, 2, 1, 0};
   pim_top #(.ADDR_W(ADDR_W)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .periph_flags(periph_flags),
      .periph_irq_req(periph_irq_req), .irq(irq));
   pim_flag_src u_src (.pclk(pclk), .presetn(presetn), .set_ev(set_ev), .clr_ev(clr_ev),
      .periph_flags(periph_flags));
   initial begin forever #50 pclk = ~pclk; end
   ////////////////////////////////////////////////////////////////////////////
   // One APB transfer; request held until pready is seen high at an edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask
   // Flag events take one edge in the model and the status one more, so check at the second negedge.
   task automatic ev(input logic [7:0] s, input logic [7:0] c);
      @(posedge pclk);
      {set_ev, clr_ev} <= {s, c};
      @(posedge pclk);
      {set_ev, clr_ev} <= 16'h0000;
      repeat (2) @(negedge pclk);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #300000;
      fail_count++;
      results();
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("mask reset", pim_pkg::PIM_OFS_MASK, 32'h0);
      apb(1'b1, pim_pkg::PIM_OFS_MASK, 32'h0000_00FF);
      rd_chk("mask ones", pim_pkg::PIM_OFS_MASK, 32'h0000_00FF);
      apb(1'b1, pim_pkg::PIM_OFS_MASK, 32'h0000_00A5);
      rd_chk("mask pattern", pim_pkg::PIM_OFS_MASK, 32'h0000_00A5);
      $display("test registers done");
      foreach (src[i]) begin
         b = 8'h01 << src[i];
         apb(1'b1, pim_pkg::PIM_OFS_CTRL, 32'h0000_00C0);
         apb(1'b1, pim_pkg::PIM_OFS_MASK, {24'h0, b});
         ev(b, 8'h00);
         `CHK("request on", 1'b1, periph_irq_req)
         apb(1'b1, pim_pkg::PIM_OFS_MASK, {24'h0, 8'h4F & ~b});
         @(negedge pclk);
         `CHK("request masked", 1'b0, periph_irq_req)
         rd_chk("flag view", pim_pkg::PIM_OFS_FLAG, {24'h0, b});
         apb(1'b1, pim_pkg::PIM_OFS_MASK, {24'h0, b});
         apb(1'b1, pim_pkg::PIM_OFS_CTRL, 32'h0000_0080);
         @(negedge pclk);
         `CHK("group off", 1'b0, periph_irq_req)
         apb(1'b1, pim_pkg::PIM_OFS_CTRL, 32'h0000_0040);
         @(negedge pclk);
         `CHK("global off", 1'b0, periph_irq_req)
         ev(8'h00, 8'hFF);
      end
      $display("test gating done");
      // Each source rose twice through its gate above; one read empties the status.
      rd_chk("status gated", pim_pkg::PIM_OFS_STAT, 32'h0000_004F);
      apb(1'b1, pim_pkg::PIM_OFS_MASK, 32'h0000_0001);
      apb(1'b1, pim_pkg::PIM_OFS_IMSK, 32'h0000_0001);
      ev(8'h01, 8'h00);
      `CHK("irq raised", 1'b1, irq)
      rd_chk("status", pim_pkg::PIM_OFS_STAT, 32'h0000_0001);
      @(negedge pclk);
      `CHK("irq cleared", 1'b0, irq)
      apb(1'b1, pim_pkg::PIM_OFS_IMSK, 32'h0);
      ev(8'h00, 8'h01);
      ev(8'h01, 8'h00);
      `CHK("irq masked", 1'b0, irq)
      rd_chk("status masked", pim_pkg::PIM_OFS_STAT, 32'h0000_0001);
      apb(1'b0, 8'hA0, 32'h0);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped data", 32'h0, rd)
      $display("test interrupt and bus done");
      results();
   end
endmodule

bind pim_top pim_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_flags(periph_flags),
   .periph_irq_req(periph_irq_req), .irq(irq));
